//--- hpw_pkg.sv
// Constants and state type of the host power watchdog supervisor.
// Assumes one 100 MHz clock; every slower rate derives from it.
package hpw_pkg;

   // APB register byte addresses
   localparam logic [7:0] ADDR_CMD_DATA = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_REPLY = 8'h08;
   localparam logic [7:0] ADDR_TEMP_CFG = 8'h0c;
   localparam logic [7:0] ADDR_KEY_CFG = 8'h10;
   localparam logic [7:0] ADDR_DISP_CFG = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   localparam logic [7:0] ADDR_SNAP0 = 8'h20;
   localparam logic [7:0] ADDR_SNAP1 = 8'h24;
   localparam logic [7:0] ADDR_SNAP2 = 8'h28;
   localparam logic [7:0] ADDR_SNAP3 = 8'h2c;

   // Command and reply type codes
   localparam logic [7:0] CMD_ATX_CFG = 8'h1c;
   localparam logic [7:0] CMD_WDOG = 8'h1d;
   localparam logic [7:0] CMD_STATUS = 8'h1e;
   localparam logic [7:0] REPLY_BIT = 8'h40;
   localparam logic [7:0] REPLY_ERR = 8'h80;
   localparam logic [7:0] STATUS_LEN = 8'h0f;

   // Function mask and reply word bit positions
   localparam int FN_AUTO_POL = 0;
   localparam int FN_RST_INV = 1;
   localparam int FN_PWR_INV = 2;
   localparam int FN_BLANK = 4;
   localparam int FN_KP_RST = 5;
   localparam int FN_KP_PON = 6;
   localparam int FN_KP_POFF = 7;
   localparam int REPLY_FRESH = 16;

   // Values after reset and after a reboot
   localparam logic [7:0] FN_MASK_RST = 8'h00;
   localparam logic [7:0] PULSE_LEN_RST = 8'h20;
   localparam logic SENSE_SEL_RST = 1'b1;
   localparam logic SENSE_INTERNAL = 1'b1;

   // Timing: 1/32 s tick, figures in milliseconds converted to ticks
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_HZ = 32;
   localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int unsigned KEY_HOLD_MS = 4000;
   localparam int unsigned KEY_TAP_MS = 250;
   localparam int unsigned RST_PULSE_MS = 1000;
   localparam int unsigned EXTEND_MS = 5000;
   localparam logic [7:0] KEY_HOLD_TICKS = 8'(KEY_HOLD_MS * TICK_HZ / 1000);
   localparam logic [7:0] KEY_TAP_TICKS = 8'((KEY_TAP_MS * TICK_HZ + 999) / 1000);
   localparam logic [7:0] RST_PULSE_TICKS = 8'(RST_PULSE_MS * TICK_HZ / 1000);
   localparam logic [7:0] EXTEND_TICKS = 8'(EXTEND_MS * TICK_HZ / 1000);

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RST = 5'b00010,
      ST_PON = 5'b00100,
      ST_POFF = 5'b01000,
      ST_EXT = 5'b10000
   } hpw_state_t;

endpackage

//--- hpw_sync.sv
// Two-flop synchroniser for a group of independent asynchronous levels.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/1ns
`default_nettype none
module hpw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- hpw_tick_div.sv
// Enable-driven divider: one-cycle tick after every DIV enable pulses.
// Assumes en is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module hpw_tick_div #(
   parameter int unsigned DIV = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Rate
   input wire logic en,
   output logic tick
);
   localparam int W = $clog2(DIV + 1);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (en)
         begin
            if (cnt_q == W'(DIV - 1))
            begin
               cnt_q <= '0;
               tick <= 1'b1;
            end
            else
            begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- hpw_supervisor.sv
// Host power and reset supervisor with host watchdog, APB register slave.
// Assumes pins and keys are asynchronous levels, keys active high, and
// the power and reset lines are pulled to their idle level externally.
//
// Notes on behaviour
// - Blanking enabled and host sensed off: blank display, backlight off.
// - Sense select 1 uses internal +5v sense; 0 uses GPIO pin 1.
// - Keep watching keys while host off; sense rising reboots device.
// - Function mask: 0x20 kp reset, 0x40 kp power-on, 0x80 off, 0x10 blank.
// - Mask 0x02 reset drives high, 0x04 power high, 0x01 auto polarity.
// - Optional second byte: pulse length in 1/32 s, 255 gives 8 s.
// - Config command 0x1C, length 1 to 3, replies 0x5C empty.
// - Watchdog timeout zero disables the watchdog, running or not.
// - Unfed watchdog resets host using configured reset line behaviour.
// - Watchdog off at power-up; after firing no reset until re-enabled.
// - Watchdog command 0x1D, one byte, replies 0x5D empty.
// - Status 0x1E replies 0x5E, 15 bytes: mask, counter, sense select.
// - Status bytes 1-6 report temperature and key masks; 0 and 12 zero.
// - Host on, confirm held 4 s: reset pulse 1 s, reboot, busy.
// - Host off, confirm 0.25 s: power pulse configured length, reboot.
// - Host on, cancel held 4 s: power pulse, holding extends up to 5 s.
// - Lines float except during pulses, driven at selected polarity.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module hpw_supervisor
   import hpw_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host sense and keys
   input wire logic sense_5v,
   input wire logic sense_gpio1,
   input wire logic key_confirm,
   input wire logic key_cancel,
   // Host power and reset lines
   input wire logic pwr_line_i,
   output logic pwr_line_o,
   output logic pwr_line_oe,
   input wire logic rst_line_i,
   output logic rst_line_o,
   output logic rst_line_oe,
   // Display and device reboot
   output logic lcd_blank,
   output logic backlight_off,
   output logic self_reboot
);
   hpw_state_t state_q;
   logic [5:0] pins_s;
   logic s_5v, s_gpio, s_ok, s_cancel, s_pwr, s_rst;
   logic tick32, tick_sec;
   logic host_on, host_on_q, booting;
   logic [7:0] fn_q, pulse_len_q, wd_cnt_q, cnt_q;
   logic sense_sel_q, wd_fire_q, reboot_after_q;
   logic [31:0] data_q, temp_cfg_q, disp_cfg_q, reply_q;
   logic [15:0] key_cfg_q;
   logic [119:0] snap_q;
   logic [127:0] snap_w;
   logic [7:0] ok_hold_q, cancel_hold_q;
   logic ok_arm_q, cancel_arm_q;
   logic pwr_idle_q, rst_idle_q, pwr_drive, rst_drive;
   logic access, done, wr, mapped, cmd_wr, cmd_ok, busy;
   logic [7:0] cmd_type, cmd_len;
   logic [31:0] rd_word;

   hpw_sync #(.W(6)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({sense_5v, sense_gpio1, key_confirm, key_cancel, pwr_line_i, rst_line_i}),
      .q(pins_s)
   );
   assign {s_5v, s_gpio, s_ok, s_cancel, s_pwr, s_rst} = pins_s;

   hpw_tick_div #(.DIV(TICK_DIV)) u_tick32 (
      .clk(pclk),
      .rst_n(presetn),
      .en(1'b1),
      .tick(tick32)
   );
   hpw_tick_div #(.DIV(TICK_HZ)) u_tick_sec (
      .clk(pclk),
      .rst_n(presetn),
      .en(tick32),
      .tick(tick_sec)
   );

   assign host_on = (sense_sel_q == SENSE_INTERNAL) ? s_5v : s_gpio;
   assign busy = (state_q != ST_IDLE);
   assign booting = self_reboot;

   // APB: one wait cycle, effects at the edge where pready is sampled high
   assign access = psel & penable;
   assign done = access & pready;
   assign wr = done & pwrite;
   assign cmd_type = pwdata[7:0];
   assign cmd_len = pwdata[15:8];
   assign cmd_wr = wr & (paddr == ADDR_CMD) & !busy;
   assign cmd_ok = ((cmd_type == CMD_ATX_CFG) && (cmd_len >= 8'h01) && (cmd_len <= 8'h03))
      || ((cmd_type == CMD_WDOG) && (cmd_len == 8'h01))
      || ((cmd_type == CMD_STATUS) && (cmd_len == 8'h00));
   assign snap_w = {8'h00, snap_q};

   always_comb
   begin
      mapped = 1'b1;
      rd_word = 32'h0;
      unique case (paddr)
         ADDR_CMD_DATA: rd_word = data_q;
         ADDR_CMD: rd_word = 32'h0;
         ADDR_REPLY: rd_word = reply_q;
         ADDR_TEMP_CFG: rd_word = temp_cfg_q;
         ADDR_KEY_CFG: rd_word = {16'h0, key_cfg_q};
         ADDR_DISP_CFG: rd_word = disp_cfg_q;
         ADDR_STATE: rd_word = {17'h0, wd_fire_q, host_on, state_q, wd_cnt_q};
         ADDR_SNAP0: rd_word = snap_w[31:0];
         ADDR_SNAP1: rd_word = snap_w[63:32];
         ADDR_SNAP2: rd_word = snap_w[95:64];
         ADDR_SNAP3: rd_word = snap_w[127:96];
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= access & !pready;
         pslverr <= access & !pready & !mapped;
         if (access && !pready)
         begin
            prdata <= pwrite ? 32'h0 : rd_word;
         end
      end
   end

   // Software-side configuration; a reboot restores power-up mask, pulse length and sense select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_q <= 32'h0;
         temp_cfg_q <= 32'h0;
         key_cfg_q <= 16'h0;
         disp_cfg_q <= 32'h0;
         fn_q <= FN_MASK_RST;
         pulse_len_q <= PULSE_LEN_RST;
         sense_sel_q <= SENSE_SEL_RST;
      end
      else if (booting)
      begin
         fn_q <= FN_MASK_RST;
         pulse_len_q <= PULSE_LEN_RST;
         sense_sel_q <= SENSE_SEL_RST;
      end
      else
      begin
         if (wr && paddr == ADDR_CMD_DATA)
            data_q <= pwdata;
         if (wr && paddr == ADDR_TEMP_CFG)
            temp_cfg_q <= pwdata;
         if (wr && paddr == ADDR_KEY_CFG)
            key_cfg_q <= pwdata[15:0];
         if (wr && paddr == ADDR_DISP_CFG)
            disp_cfg_q <= pwdata;
         if (cmd_wr && cmd_ok && cmd_type == CMD_ATX_CFG)
         begin
            fn_q <= data_q[7:0];
            if (cmd_len >= 8'h02)
               pulse_len_q <= data_q[15:8];
            if (cmd_len == 8'h03)
               sense_sel_q <= data_q[16];
         end
      end
   end

   // Reply word: type, length, and a fresh flag cleared by reading it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reply_q <= 32'h0;
         snap_q <= '0;
      end
      else if (cmd_wr)
      begin
         reply_q[7:0] <= cmd_type | REPLY_BIT | (cmd_ok ? 8'h00 : REPLY_ERR);
         reply_q[15:8] <= (cmd_ok && cmd_type == CMD_STATUS) ? STATUS_LEN : 8'h00;
         reply_q[REPLY_FRESH] <= 1'b1;
         if (cmd_ok && cmd_type == CMD_STATUS)
         begin
            snap_q <= {disp_cfg_q[31:24], disp_cfg_q[23:16], 8'h00, 7'h00, sense_sel_q,
               disp_cfg_q[15:8], disp_cfg_q[7:0], wd_cnt_q, fn_q, key_cfg_q[15:8],
               key_cfg_q[7:0], temp_cfg_q, 8'h00};
         end
      end
      else if (done && !pwrite && paddr == ADDR_REPLY)
      begin
         reply_q[REPLY_FRESH] <= 1'b0;
      end
   end

   // watchdog counter, one decrement per second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_cnt_q <= 8'h00;
         wd_fire_q <= 1'b0;
      end
      else if (booting)
      begin
         wd_cnt_q <= 8'h00;
         wd_fire_q <= 1'b0;
      end
      else
      begin
         // load or disable on each feed
         if (cmd_wr && cmd_ok && cmd_type == CMD_WDOG)
            wd_cnt_q <= data_q[7:0];
         else if (tick_sec && wd_cnt_q != 8'h00)
            wd_cnt_q <= wd_cnt_q - 8'h01;
         // expiry pends until the sequencer is free; set wins over clear
         if (tick_sec && wd_cnt_q == 8'h01 && !(cmd_wr && cmd_ok && cmd_type == CMD_WDOG))
            wd_fire_q <= 1'b1;
         else if (state_q == ST_IDLE)
            wd_fire_q <= 1'b0;
      end
   end

   // Key hold timers in 1/32 s; a key must be released once before it arms
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ok_hold_q <= 8'h00;
         cancel_hold_q <= 8'h00;
         ok_arm_q <= 1'b0;
         cancel_arm_q <= 1'b0;
      end
      else if (booting)
      begin
         ok_hold_q <= 8'h00;
         cancel_hold_q <= 8'h00;
         ok_arm_q <= 1'b0;
         cancel_arm_q <= 1'b0;
      end
      else
      begin
         if (!s_ok)
            ok_arm_q <= 1'b1;
         if (!s_cancel)
            cancel_arm_q <= 1'b1;
         if (!s_ok || !ok_arm_q)
            ok_hold_q <= 8'h00;
         else if (tick32 && ok_hold_q != 8'hff)
            ok_hold_q <= ok_hold_q + 8'h01;
         if (!s_cancel || !cancel_arm_q)
            cancel_hold_q <= 8'h00;
         else if (tick32 && cancel_hold_q != 8'hff)
            cancel_hold_q <= cancel_hold_q + 8'h01;
      end
   end

   // Pulse sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         reboot_after_q <= 1'b0;
         self_reboot <= 1'b0;
         host_on_q <= 1'b0;
      end
      else
      begin
         self_reboot <= 1'b0;
         host_on_q <= host_on;
         unique case (state_q)
            ST_IDLE:
            begin
               if (wd_fire_q)
               begin
                  state_q <= ST_RST;
                  cnt_q <= RST_PULSE_TICKS;
                  reboot_after_q <= 1'b0;
               end
               else if (host_on && fn_q[FN_KP_RST] && ok_hold_q == KEY_HOLD_TICKS)
               begin
                  state_q <= ST_RST;
                  cnt_q <= RST_PULSE_TICKS;
                  reboot_after_q <= 1'b1;
               end
               else if (!host_on && fn_q[FN_KP_PON] && ok_hold_q == KEY_TAP_TICKS)
               begin
                  state_q <= ST_PON;
                  cnt_q <= pulse_len_q;
                  reboot_after_q <= 1'b1;
               end
               else if (host_on && fn_q[FN_KP_POFF] && cancel_hold_q == KEY_HOLD_TICKS)
               begin
                  state_q <= ST_POFF;
                  cnt_q <= pulse_len_q;
               end
               else if (host_on && !host_on_q)
               begin
                  self_reboot <= 1'b1;
               end
            end
            ST_RST, ST_PON:
            begin
               if (tick32 && cnt_q <= 8'h01)
               begin
                  state_q <= ST_IDLE;
                  self_reboot <= reboot_after_q;
               end
               else if (tick32)
                  cnt_q <= cnt_q - 8'h01;
            end
            ST_POFF:
            begin
               if (tick32 && cnt_q <= 8'h01)
               begin
                  state_q <= s_cancel ? ST_EXT : ST_IDLE;
                  cnt_q <= EXTEND_TICKS;
               end
               else if (tick32)
                  cnt_q <= cnt_q - 8'h01;
            end
            ST_EXT:
            begin
               if (!s_cancel || (tick32 && cnt_q <= 8'h01))
                  state_q <= ST_IDLE;
               else if (tick32)
                  cnt_q <= cnt_q - 8'h01;
            end
         endcase
      end
   end

   // drive level: opposite of the sensed idle level under auto polarity
   assign pwr_drive = fn_q[FN_AUTO_POL] ? !pwr_idle_q : fn_q[FN_PWR_INV];
   assign rst_drive = fn_q[FN_AUTO_POL] ? !rst_idle_q : fn_q[FN_RST_INV];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_idle_q <= 1'b1;
         rst_idle_q <= 1'b1;
         pwr_line_o <= 1'b0;
         pwr_line_oe <= 1'b0;
         rst_line_o <= 1'b0;
         rst_line_oe <= 1'b0;
         lcd_blank <= 1'b0;
         backlight_off <= 1'b0;
      end
      else
      begin
         // idle level is only meaningful while nobody else drives the line
         if (!pwr_line_oe && state_q == ST_IDLE)
            pwr_idle_q <= s_pwr;
         if (!rst_line_oe && state_q == ST_IDLE)
            rst_idle_q <= s_rst;
         pwr_line_oe <= (state_q == ST_PON) || (state_q == ST_POFF) || (state_q == ST_EXT);
         pwr_line_o <= pwr_drive;
         rst_line_oe <= (state_q == ST_RST);
         rst_line_o <= rst_drive;
         lcd_blank <= fn_q[FN_BLANK] & !host_on;
         backlight_off <= fn_q[FN_BLANK] & !host_on;
      end
   end
endmodule
`default_nettype wire

//--- hpw_host_model.sv
// Host side: pulled-up power and reset pins, and a host supply that
// toggles when a power pulse ends. Assumes split pin ports.
`timescale 1ns/1ns
`default_nettype none
module hpw_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Supervisor drive
   input wire logic pwr_o,
   input wire logic pwr_oe,
   input wire logic rst_o,
   input wire logic rst_oe,
   // Pin levels and host supply
   output logic pwr_i,
   output logic rst_i,
   output logic host_on
);
   logic pwr_oe_q;
   assign pwr_i = pwr_oe ? pwr_o : 1'b1;
   assign rst_i = rst_oe ? rst_o : 1'b1;
   // Supply reacts at pulse end, as a panel switch does
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_oe_q <= 1'b0;
         host_on <= 1'b0;
      end
      else
      begin
         pwr_oe_q <= pwr_oe;
         if (pwr_oe_q && !pwr_oe)
         begin
            host_on <= !host_on;
         end
      end
   end
endmodule
`default_nettype wire

//--- hpw_supervisor_checker.sv
// Assertions on the supervisor's APB, line pulses and display outputs.
// Assumes binding to hpw_supervisor; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module hpw_supervisor_checker
   import hpw_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Lines and display
   input wire logic pwr_line_o,
   input wire logic pwr_line_oe,
   input wire logic rst_line_o,
   input wire logic rst_line_oe,
   input wire logic lcd_blank,
   input wire logic backlight_off,
   input wire logic self_reboot
);
   localparam int RST_LEN = 32 * TICK_DIV;
   logic [15:0] pwr_len_q;
   logic [15:0] rst_len_q;
   logic unmapped;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   assign unmapped = paddr[1:0] != 2'b00 || paddr == 8'h1c || paddr > ADDR_SNAP3;
   // Cycles each line has been driven; a float clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_len_q <= 16'h0000;
         rst_len_q <= 16'h0000;
      end
      else
      begin
         pwr_len_q <= pwr_line_oe ? pwr_len_q + 16'h0001 : 16'h0000;
         rst_len_q <= rst_line_oe ? rst_len_q + 16'h0001 : 16'h0000;
      end
   end
   sequence s_first_acc;
      psel && penable && !$past(penable);
   endsequence
   sequence s_answer;
      !pready ##1 pready ##1 !pready;
   endsequence
   a_ready_wait: assert property (s_first_acc |-> s_answer)
      else $error("pready not one cycle");
   a_err_map: assert property (pready |-> pslverr == unmapped)
      else $error("pslverr wrong");
   a_err_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
      else $error("refused read returned data");
   a_reply_type: assert property (pready && !pwrite && paddr == ADDR_REPLY && prdata[16]
      |-> prdata[6])
      else $error("reply type lacks 0x40");
   a_blank_pair: assert property (lcd_blank == backlight_off)
      else $error("blank and backlight differ");
   a_reboot_pulse: assert property (self_reboot |=> !self_reboot)
      else $error("reboot longer than a cycle");
   a_pwr_steady: assert property (pwr_line_oe && $past(pwr_line_oe) |-> $stable(pwr_line_o))
      else $error("power level changed in pulse");
   a_rst_steady: assert property (rst_line_oe && $past(rst_line_oe) |-> $stable(rst_line_o))
      else $error("reset level changed in pulse");
   a_rst_len: assert property ($fell(rst_line_oe)
      |-> rst_len_q >= RST_LEN - 2 && rst_len_q <= RST_LEN + 2)
      else $error("reset pulse not one second");
   a_pwr_len: assert property ($fell(pwr_line_oe) |-> pwr_len_q >= TICK_DIV)
      else $error("power pulse too short");
endmodule
bind hpw_supervisor hpw_supervisor_checker #(.TICK_DIV(TICK_DIV)) u_hpw_supervisor_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pwr_line_o(pwr_line_o), .pwr_line_oe(pwr_line_oe), .rst_line_o(rst_line_o),
   .rst_line_oe(rst_line_oe), .lcd_blank(lcd_blank), .backlight_off(backlight_off),
   .self_reboot(self_reboot));
`default_nettype wire

//--- hpw_supervisor_tb_top.sv
// Self-checking bench: APB master, command table, key and watchdog cases.
// Assumes a fast tick divider so one second is 128 cycles.
`timescale 1ns/1ns
`default_nettype none
module hpw_supervisor_tb_top
   import hpw_pkg::*;
;
   localparam int TDIV = 4;
   typedef struct packed {
      logic [7:0] ty;
      logic [7:0] ln;
      logic [7:0] d0;
      logic [7:0] rl;
      logic bad;
   } hpw_row_t;
   hpw_row_t rows [5];
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sense_gpio1 = 1'b0;
   logic key_confirm = 1'b0;
   logic key_cancel = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, host_on, pwr_line_i, pwr_line_o, pwr_line_oe;
   logic rst_line_i, rst_line_o, rst_line_oe, lcd_blank, backlight_off, self_reboot;
   logic [31:0] v, e;
   logic er, got, lv;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int reboots = 0;
   int tw, tl, rb;
   hpw_supervisor #(.TICK_DIV(TDIV)) u_hpw_supervisor (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sense_5v(host_on), .sense_gpio1(sense_gpio1), .key_confirm(key_confirm),
      .key_cancel(key_cancel), .pwr_line_i(pwr_line_i), .pwr_line_o(pwr_line_o),
      .pwr_line_oe(pwr_line_oe), .rst_line_i(rst_line_i), .rst_line_o(rst_line_o),
      .rst_line_oe(rst_line_oe), .lcd_blank(lcd_blank), .backlight_off(backlight_off),
      .self_reboot(self_reboot));
   hpw_host_model u_hpw_host_model (
      .pclk(pclk), .presetn(presetn), .pwr_o(pwr_line_o), .pwr_oe(pwr_line_oe),
      .rst_o(rst_line_o), .rst_oe(rst_line_oe), .pwr_i(pwr_line_i), .rst_i(rst_line_i),
      .host_on(host_on));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x)
      begin
         err_total++;
         $display("MISMATCH %0t: saw %h want %h", $time, s, x);
      end
   endtask
   task automatic rng(input int x, input int lo, input int hi);
      chk({31'h0, x >= lo && x <= hi}, 32'h1);
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      rng(n, 0, 19);
      v = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(v, x);
   endtask
   task automatic cmd(input logic [7:0] t, input logic [7:0] l, input logic [31:0] d);
      apb(1'b1, ADDR_CMD_DATA, d);
      apb(1'b1, ADDR_CMD, {16'h0, l, t});
   endtask
   function automatic logic oe_f(input logic w);
      return w ? rst_line_oe : pwr_line_oe;
   endfunction
   // Wait for a pulse on one line, then time it
   task automatic meas(input logic w, input int lim);
      tw = 0;
      tl = 0;
      while (oe_f(w) !== 1'b1 && tw < lim)
      begin
         @(posedge pclk);
         tw++;
      end
      got = oe_f(w) === 1'b1;
      lv = w ? rst_line_o : pwr_line_o;
      while (oe_f(w) === 1'b1 && tl < 2000)
      begin
         @(posedge pclk);
         tl++;
      end
   endtask
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      reboots = reboots + (self_reboot === 1'b1);
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         give_verdict();
      end
   end
   initial
   begin
      rows = '{'{CMD_ATX_CFG, 8'h01, 8'h10, 8'h00, 1'b0}, '{CMD_WDOG, 8'h01, 8'h00, 8'h00, 1'b0},
         '{CMD_STATUS, 8'h00, 8'h00, STATUS_LEN, 1'b0}, '{CMD_ATX_CFG, 8'h04, 8'h10, 8'h00, 1'b1},
         '{CMD_WDOG, 8'h02, 8'h00, 8'h00, 1'b1}};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ADDR_REPLY, 32'h0);
      rdc(ADDR_STATE, {19'h0, ST_IDLE, 8'h00});
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("end of test reset");
      foreach (rows[i])
      begin
         cmd(rows[i].ty, rows[i].ln, {24'h0, rows[i].d0});
         e = {15'h0, 1'b1, rows[i].rl, rows[i].ty | REPLY_BIT | (rows[i].bad ? REPLY_ERR : 8'h00)};
         rdc(ADDR_REPLY, e);
      end
      rdc(ADDR_REPLY, {16'h0, 8'h00, CMD_WDOG | REPLY_BIT | REPLY_ERR});
      chk({30'h0, lcd_blank, backlight_off}, 32'h3);
      $display("end of test commands");
      apb(1'b1, ADDR_TEMP_CFG, 32'h44332211);
      apb(1'b1, ADDR_KEY_CFG, 32'h00006655);
      apb(1'b1, ADDR_DISP_CFG, 32'h0);
      cmd(CMD_STATUS, 8'h00, 32'h0);
      rdc(ADDR_SNAP0, 32'h33221100);
      rdc(ADDR_SNAP1, 32'h10665544);
      rdc(ADDR_SNAP2, 32'h01000000);
      rdc(ADDR_SNAP3, 32'h0);
      $display("end of test status");
      cmd(CMD_ATX_CFG, 8'h02, 32'h00000440);
      key_confirm <= 1'b1;
      meas(1'b0, 200);
      rng(tw, 7 * TDIV, 8 * TDIV + 8);
      rng(tl, 4 * TDIV - 1, 4 * TDIV + 1);
      chk({31'h0, lv}, 32'h0);
      key_confirm <= 1'b0;
      repeat (20) @(posedge pclk);
      rng(reboots, 1, 3);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk({31'h0, v[13]}, 32'h1);
      $display("end of test power on");
      cmd(CMD_ATX_CFG, 8'h03, 32'h00002010);
      repeat (6) @(posedge pclk);
      chk({31'h0, lcd_blank}, 32'h1);
      cmd(CMD_ATX_CFG, 8'h03, 32'h00012010);
      repeat (6) @(posedge pclk);
      chk({31'h0, lcd_blank}, 32'h0);
      $display("end of test sense select");
      cmd(CMD_ATX_CFG, 8'h01, 32'h00000002);
      cmd(CMD_WDOG, 8'h01, 32'h00000002);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk({24'h0, v[7:0]}, 32'h2);
      meas(1'b1, 400);
      rng(tw, 100, 270);
      chk({31'h0, lv}, 32'h1);
      rng(tl, 31 * TDIV + 1, 32 * TDIV);
      meas(1'b1, 600);
      chk({31'h0, got}, 32'h0);
      cmd(CMD_WDOG, 8'h01, 32'h00000003);
      cmd(CMD_WDOG, 8'h01, 32'h00000000);
      meas(1'b1, 600);
      chk({31'h0, got}, 32'h0);
      $display("end of test watchdog");
      cmd(CMD_ATX_CFG, 8'h01, 32'h00000023);
      rb = reboots;
      key_confirm <= 1'b1;
      meas(1'b1, 800);
      rng(tw, 127 * TDIV, 128 * TDIV + 8);
      rng(tl, 31 * TDIV + 1, 32 * TDIV);
      chk({31'h0, lv}, 32'h0);
      key_confirm <= 1'b0;
      repeat (4) @(posedge pclk);
      rng(reboots - rb, 1, 1);
      $display("end of test keypad reset");
      cmd(CMD_ATX_CFG, 8'h02, 32'h00000884);
      key_cancel <= 1'b1;
      meas(1'b0, 800);
      rng(tw, 127 * TDIV, 128 * TDIV + 8);
      chk({31'h0, lv}, 32'h1);
      rng(tl, 168 * TDIV - 4, 168 * TDIV + 4);
      key_cancel <= 1'b0;
      $display("end of test power off");
      give_verdict();
   end
endmodule
`default_nettype wire
